// *** design/strap_latch_boot_select.sv ***
// module: strap latch, boot select decode and ahb-lite strap registers
`default_nettype none
module strap_latch_boot_select (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // reset causes (any high holds system reset)
   input wire logic porReset,
   input wire logic lpWdtReset,
   input wire logic brownoutReset,
   input wire logic anaWdtReset,
   input wire logic glitchReset,
   // strap pads
   input wire logic boot_select_pin,
   input wire logic bootSelectDriven,
   input wire logic flash_supply_select_pin,
   input wire logic flashSupplyDriven,
   input wire logic print_gate_pin,
   input wire logic printGateDriven,
   // fuses
   input wire logic [1:0] printPolicyFuse,
   input wire logic printAltPinFuse,
   // rom print data from boot rom uart
   input wire logic romPrintTx,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // boot outputs
   output logic systemInReset,
   output slbs_pkg::slbs_boot_t bootMode,
   output logic flashSupplySel,
   output logic printEnable,
   output logic primary_serial_tx,
   output logic alt_print_pin,
   output logic [2:0] funcPinIn
);
   // ------------------------------------------------------------------
   // pads
   // ------------------------------------------------------------------
   slbs_pkg::slbs_strap_t padLevel;

   slbs_pin_pad #(.PULL(slbs_pkg::BOOT_SELECT_PULL)) uBootPad (
      .padIn(boot_select_pin),
      .padDriven(bootSelectDriven),
      .level(padLevel.bootSelect),
      .funcIn(funcPinIn[slbs_pkg::BOOT_SELECT_POS])
   );
   slbs_pin_pad #(.PULL(slbs_pkg::FLASH_SUPPLY_PULL)) uFlashPad (
      .padIn(flash_supply_select_pin),
      .padDriven(flashSupplyDriven),
      .level(padLevel.flashSupply),
      .funcIn(funcPinIn[slbs_pkg::FLASH_SUPPLY_POS])
   );
   slbs_pin_pad #(.PULL(slbs_pkg::PRINT_GATE_PULL)) uPrintPad (
      .padIn(print_gate_pin),
      .padDriven(printGateDriven),
      .level(padLevel.printGate),
      .funcIn(funcPinIn[slbs_pkg::PRINT_GATE_POS])
   );

   // ------------------------------------------------------------------
   // strap latch
   // ------------------------------------------------------------------
   // resetn also loads the strap latch with the pull defaults; otherwise the
   // latch follows the system reset causes and keeps the captured bits
   slbs_pkg::slbs_strap_t strap_q, strap_d;
   logic sysReset;

   always_comb begin
      sysReset = porReset | lpWdtReset | brownoutReset
         | anaWdtReset | glitchReset;
      strap_d = strap_q;
      if (sysReset) begin
         strap_d = padLevel;
      end
      // after release pads no longer feed the latch
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         strap_q <= '{printGate: slbs_pkg::PRINT_GATE_PULL,
                      flashSupply: slbs_pkg::FLASH_SUPPLY_PULL,
                      bootSelect: slbs_pkg::BOOT_SELECT_PULL};
      end else begin
         strap_q <= strap_d;
      end
   end

   assign systemInReset = sysReset;

   // ------------------------------------------------------------------
   // decode
   // ------------------------------------------------------------------
   logic [1:0] printPolicy_q, printPolicy_d;
   logic altFuse_q, altFuse_d;

   // fuses are shadowed while system reset is high, like the straps
   always_comb begin
      printPolicy_d = printPolicy_q;
      altFuse_d = altFuse_q;
      if (sysReset) begin
         printPolicy_d = printPolicyFuse;
         altFuse_d = printAltPinFuse;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         printPolicy_q <= slbs_pkg::PRINT_ALWAYS;
         altFuse_q <= 1'b0;
      end else begin
         printPolicy_q <= printPolicy_d;
         altFuse_q <= altFuse_d;
      end
   end

   slbs_boot_decode uDecode (
      .strap(strap_q),
      .printPolicy(printPolicy_q),
      .bootMode(bootMode),
      .printEnable(printEnable)
   );

   // rom print routing: idle high on the unused pin
   always_comb begin
      primary_serial_tx = altFuse_q ? 1'b1 : romPrintTx;
      alt_print_pin = altFuse_q ? romPrintTx : 1'b1;
   end

   // ------------------------------------------------------------------
   // flash supply override
   // ------------------------------------------------------------------
   logic [1:0] flashCfg_q, flashCfg_d;

   always_comb begin
      if (flashCfg_q[slbs_pkg::OVR_ENABLE_POS]) begin
         flashSupplySel = flashCfg_q[slbs_pkg::OVR_VALUE_POS];
      end else begin
         // 0 -> 3.3 V, 1 -> 1.8 V
         flashSupplySel = strap_q.flashSupply;
      end
   end

   // ------------------------------------------------------------------
   // ahb-lite slave, zero wait state
   // ------------------------------------------------------------------
   logic wrPend_q, wrPend_d;
   logic [11:0] addr_q, addr_d;
   logic [31:0] rdata_q, rdata_d;
   logic take;

   always_comb begin
      take = hsel & hready & (htrans == slbs_pkg::HTRANS_NONSEQ);
      wrPend_d = take & hwrite;
      addr_d = take ? haddr : addr_q;
      rdata_d = rdata_q;
      flashCfg_d = flashCfg_q;
      if (take && !hwrite) begin
         unique case (haddr)
            slbs_pkg::STRAP_CAPTURE_OFS:
               rdata_d = {29'h0, strap_q};
            slbs_pkg::FLASH_SUPPLY_CFG_OFS:
               rdata_d = {30'h0, flashCfg_q};
            slbs_pkg::BOOT_STATUS_OFS:
               rdata_d = {28'h000_0000, printEnable, flashSupplySel,
                  bootMode};
            slbs_pkg::FUSE_SHADOW_OFS:
               rdata_d = {29'h0, altFuse_q, printPolicy_q};
            default:
               rdata_d = slbs_pkg::RDATA_RST;
         endcase
      end
      // only the config word is writable; strap word ignores writes
      if (wrPend_q && addr_q == slbs_pkg::FLASH_SUPPLY_CFG_OFS) begin
         flashCfg_d = hwdata[1:0];
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         wrPend_q <= 1'b0;
         addr_q <= slbs_pkg::STRAP_CAPTURE_OFS;
         rdata_q <= slbs_pkg::RDATA_RST;
         flashCfg_q <= slbs_pkg::FLASH_CFG_RST;
      end else begin
         wrPend_q <= wrPend_d;
         addr_q <= addr_d;
         rdata_q <= rdata_d;
         flashCfg_q <= flashCfg_d;
      end
   end

   assign hrdata = rdata_q;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

endmodule
`default_nettype wire

// *** design/slbs_pkg.sv ***
// package: strap latch boot select constants and types
`default_nettype none
package slbs_pkg;
   // -------------------------------------------------------------------
   // register map
   // -------------------------------------------------------------------
   localparam logic [11:0] STRAP_CAPTURE_OFS = 12'h000;
   localparam logic [11:0] FLASH_SUPPLY_CFG_OFS = 12'h004;
   localparam logic [11:0] BOOT_STATUS_OFS = 12'h008;
   localparam logic [11:0] FUSE_SHADOW_OFS = 12'h00C;
   // -------------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------------
   localparam int BOOT_SELECT_POS = 0;
   localparam int FLASH_SUPPLY_POS = 1;
   localparam int PRINT_GATE_POS = 2;
   localparam int OVR_VALUE_POS = 0;
   localparam int OVR_ENABLE_POS = 1;
   // -------------------------------------------------------------------
   // reset values and pull defaults
   // -------------------------------------------------------------------
   localparam logic BOOT_SELECT_PULL = 1'b1;
   localparam logic FLASH_SUPPLY_PULL = 1'b0;
   localparam logic PRINT_GATE_PULL = 1'b0;
   localparam logic [1:0] FLASH_CFG_RST = 2'h0;
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;
   // -------------------------------------------------------------------
   // encodings
   // -------------------------------------------------------------------
   localparam logic [1:0] PRINT_ALWAYS = 2'h0;
   localparam logic [1:0] PRINT_GATE_LOW = 2'h1;
   localparam logic [1:0] PRINT_GATE_HIGH = 2'h2;
   localparam logic [1:0] PRINT_NEVER = 2'h3;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic FLASH_3V3 = 1'b0;
   localparam logic FLASH_1V8 = 1'b1;

   typedef enum logic [1:0] {
      SLBS_BOOT_FLASH,
      SLBS_BOOT_DOWNLOAD,
      SLBS_BOOT_ILLEGAL
   } slbs_boot_t;

   typedef struct packed {
      logic printGate;
      logic flashSupply;
      logic bootSelect;
   } slbs_strap_t;
endpackage
`default_nettype wire

// *** design/slbs_pin_pad.sv ***
// module: one strap pin with weak pull and function-mode pass-through
`default_nettype none
module slbs_pin_pad #(
   parameter logic PULL = 1'b0
) (
   // pad side
   input wire logic padIn,
   input wire logic padDriven,
   // core side
   output logic level,
   output logic funcIn
);
   // undriven pad falls to the weak pull
   always_comb begin
      level = padDriven ? padIn : PULL;
      funcIn = level;
   end
endmodule
`default_nettype wire

// *** design/slbs_boot_decode.sv ***
// module: boot mode and rom print decode from latched straps
`default_nettype none
module slbs_boot_decode (
   // inputs
   input wire slbs_pkg::slbs_strap_t strap,
   input wire logic [1:0] printPolicy,
   // outputs
   output slbs_pkg::slbs_boot_t bootMode,
   output logic printEnable
);
   always_comb begin
      if (strap.bootSelect) begin
         bootMode = slbs_pkg::SLBS_BOOT_FLASH;
      end else if (!strap.printGate) begin
         bootMode = slbs_pkg::SLBS_BOOT_DOWNLOAD;
      end else begin
         // board broke the strap contract; flagged, not trusted
         bootMode = slbs_pkg::SLBS_BOOT_ILLEGAL;
      end
      unique case (printPolicy)
         slbs_pkg::PRINT_ALWAYS: printEnable = 1'b1;
         slbs_pkg::PRINT_GATE_LOW: printEnable = !strap.printGate;
         slbs_pkg::PRINT_GATE_HIGH: printEnable = strap.printGate;
         slbs_pkg::PRINT_NEVER: printEnable = 1'b0;
      endcase
   end
endmodule
`default_nettype wire

// *** verif/slbs_chk_sva.sv ***
// checker: strap latch, print gate and bus assertions
`default_nettype none
module slbs_chk (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // reset causes, pads and fuses
   input wire logic porReset,
   input wire logic lpWdtReset,
   input wire logic brownoutReset,
   input wire logic anaWdtReset,
   input wire logic glitchReset,
   input wire logic boot_select_pin,
   input wire logic bootSelectDriven,
   input wire logic print_gate_pin,
   input wire logic printGateDriven,
   input wire logic [1:0] printPolicyFuse,
   // bus
   input wire logic hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   // boot outputs
   input wire logic systemInReset,
   input wire slbs_pkg::slbs_boot_t bootMode,
   input wire logic printEnable
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // pad level after the weak pull
   // ----------------------------------------------------------------
   logic bs;
   logic pg;
   logic rd;
   assign bs = bootSelectDriven ? boot_select_pin : 1'b1;
   assign pg = printGateDriven ? print_gate_pin : 1'b0;
   assign rd = hsel && hready && htrans == slbs_pkg::HTRANS_NONSEQ && !hwrite;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   a_sys_reset: assert property (
      systemInReset == (porReset || lpWdtReset || brownoutReset
      || anaWdtReset || glitchReset)) else $error("reset cause or wrong");
   a_boot_capture: assert property (
      systemInReset |=> bootMode == ($past(bs) ? slbs_pkg::SLBS_BOOT_FLASH
      : $past(pg) ? slbs_pkg::SLBS_BOOT_ILLEGAL
      : slbs_pkg::SLBS_BOOT_DOWNLOAD)) else $error("boot mode not captured");
   a_latch_hold: assert property (
      !systemInReset |=> $stable(bootMode)) else $error("boot mode moved");
   a_print_hold: assert property (
      !systemInReset |=> $stable(printEnable)) else $error("print moved");
   a_print_policy: assert property (
      systemInReset |=> printEnable == ($past(printPolicyFuse) == 2'h0
      || $past(printPolicyFuse) == 2'h1 && !$past(pg)
      || $past(printPolicyFuse) == 2'h2 && $past(pg)))
      else $error("print enable wrong");
   a_bus_okay: assert property (
      hreadyout && !hresp) else $error("bus not ready or not okay");
   a_unmapped_read: assert property (
      rd && haddr > slbs_pkg::FUSE_SHADOW_OFS |=> hrdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   // a capture in the same cycle would move the strap under the read
   a_strap_read: assert property (
      rd && !systemInReset && haddr == slbs_pkg::STRAP_CAPTURE_OFS |=>
      hrdata[0] == (bootMode == slbs_pkg::SLBS_BOOT_FLASH))
      else $error("strap read disagrees with boot mode");
endmodule
`default_nettype wire

// *** verif/slbs_board.sv ***
// partner: host drive or a wandering float level on the strap pads
`default_nettype none
module slbs_board (
   // clock
   input wire logic core_clk,
   // wanted levels and drive enables
   input wire logic [2:0] want,
   input wire logic [2:0] drv,
   // pad levels
   output logic [2:0] pins
);
   timeunit 1ns;
   timeprecision 1ps;
   // undriven pads wander so only the weak pull can settle them
   logic [2:0] floatQ = 3'h5;
   always @(posedge core_clk) floatQ <= ~floatQ;
   // host drive held through reset; bench never asks for print gate high
   // with boot select low, nor a high flash strap with 3.3 V flash
   assign pins = (drv & want) | (~drv & floatQ);
endmodule
`default_nettype wire

// *** verif/tb.sv ***
// testbench: strap capture, boot decode, print gating and registers
`default_nettype none
`define CHK(n, e, a) begin nCompared++; if ((a) !== (e)) begin nFail++; \
   $display("ERROR %s expected %h seen %h", n, e, a); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, resetn, hsel, hwrite, hreadyout, hresp, romPrintTx;
   logic altFuse, sysRst, priTx, altTx, flashSel, printEn;
   logic [4:0] cause;
   logic [2:0] want, drv, pins, func;
   logic [1:0] policy, htrans;
   logic [11:0] haddr;
   logic [31:0] hwdata, hrdata, rdat;
   slbs_pkg::slbs_boot_t boot;
   int nFail = 0;
   int nCompared = 0;
   slbs_board slbs_board_i (.core_clk, .want, .drv, .pins);
   strap_latch_boot_select strap_latch_boot_select_i (
      .core_clk, .resetn, .porReset(cause[0]), .lpWdtReset(cause[1]),
      .brownoutReset(cause[2]), .anaWdtReset(cause[3]),
      .glitchReset(cause[4]), .boot_select_pin(pins[0]),
      .bootSelectDriven(drv[0]), .flash_supply_select_pin(pins[1]),
      .flashSupplyDriven(drv[1]), .print_gate_pin(pins[2]),
      .printGateDriven(drv[2]), .printPolicyFuse(policy),
      .printAltPinFuse(altFuse), .romPrintTx, .hsel, .haddr, .htrans,
      .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata,
      .hreadyout, .hresp, .systemInReset(sysRst), .bootMode(boot),
      .flashSupplySel(flashSel), .printEnable(printEn),
      .primary_serial_tx(priTx), .alt_print_pin(altTx), .funcPinIn(func));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic end_sim;
      $display("compared %0d failed %0d", nCompared, nFail);
      if (nFail == 0 && nCompared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic waitRdy;
      int k;
      k = 0;
      while (hreadyout !== 1'b1) begin
         @(posedge core_clk);
         k++;
         if (k > 50) begin
            nFail++;
            end_sim();
         end
      end
   endtask
   // one single transfer: address phase, then data phase
   task automatic ahb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      @(posedge core_clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= slbs_pkg::HTRANS_NONSEQ;
      @(posedge core_clk);
      waitRdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge core_clk);
      waitRdy();
      rdat = hrdata;
   endtask
   task automatic cap(input logic [2:0] p, input logic [2:0] d,
      input logic [4:0] c);
      @(posedge core_clk);
      want <= p;
      drv <= d;
      cause <= c;
      repeat (2) @(posedge core_clk);
      cause <= 5'h0;
      @(posedge core_clk);
   endtask
   task automatic t_pull;
      // first latch a driven pattern so the pull capture must move the bits
      cap(3'h2, 3'h7, 5'h10);
      cap(3'h6, 3'h0, 5'h01);
      ahb(1'h0, slbs_pkg::STRAP_CAPTURE_OFS, 32'h0);
      `CHK("strap pull", 3'h1, rdat[2:0])
   endtask
   task automatic t_causes;
      logic [2:0] pat [5] = '{3'h2, 3'h7, 3'h0, 3'h5, 3'h3};
      slbs_pkg::slbs_boot_t expBoot;
      for (int i = 0; i < 5; i++) begin
         cap(pat[i], 3'h7, 5'(1 << i));
         want <= ~pat[i];
         repeat (2) @(posedge core_clk);
         ahb(1'h0, slbs_pkg::STRAP_CAPTURE_OFS, 32'h0);
         `CHK("strap", pat[i], rdat[2:0])
         `CHK("func pins", ~pat[i], func)
         `CHK("flash sel", pat[i][1], flashSel)
         expBoot = pat[i][0] ? slbs_pkg::SLBS_BOOT_FLASH
            : slbs_pkg::SLBS_BOOT_DOWNLOAD;
         `CHK("boot", expBoot, boot)
      end
   endtask
   task automatic t_regs;
      cap(3'h2, 3'h7, 5'h01);
      ahb(1'h1, slbs_pkg::STRAP_CAPTURE_OFS, 32'hFFFF_FFFF);
      ahb(1'h0, slbs_pkg::STRAP_CAPTURE_OFS, 32'h0);
      `CHK("strap ro", 3'h2, rdat[2:0])
      `CHK("boot ro", slbs_pkg::SLBS_BOOT_DOWNLOAD, boot)
      ahb(1'h1, slbs_pkg::FLASH_SUPPLY_CFG_OFS, 32'h0000_0002);
      @(posedge core_clk);
      `CHK("flash override", slbs_pkg::FLASH_3V3, flashSel)
      ahb(1'h0, slbs_pkg::FLASH_SUPPLY_CFG_OFS, 32'h0);
      `CHK("flash cfg", 32'h0000_0002, rdat)
      ahb(1'h1, slbs_pkg::FLASH_SUPPLY_CFG_OFS, 32'h0000_0000);
      @(posedge core_clk);
      `CHK("flash strap", slbs_pkg::FLASH_1V8, flashSel)
      ahb(1'h0, 12'h010, 32'h0);
      `CHK("unmapped", 32'h0000_0000, rdat)
   endtask
   task automatic t_print;
      logic exp;
      for (int k = 0; k < 8; k++) begin
         policy <= 2'(k >> 1);
         altFuse <= k[0];
         romPrintTx <= 1'b0;
         cap({k[0], 2'h1}, 3'h7, 5'h01);
         exp = (k < 3) || (k == 5);
         `CHK("print", exp, printEn)
         `CHK("primary tx", k[0], priTx)
         `CHK("alt tx", ~k[0], altTx)
         ahb(1'h0, slbs_pkg::FUSE_SHADOW_OFS, 32'h0);
         `CHK("fuse shadow", {k[0], 2'(k >> 1)}, rdat[2:0])
         ahb(1'h0, slbs_pkg::BOOT_STATUS_OFS, 32'h0);
         `CHK("boot status", {exp, 3'h0}, rdat[3:0])
      end
   endtask
   initial begin
      resetn = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      htrans = 2'h0;
      haddr = 12'h000;
      hwdata = 32'h0;
      cause = 5'h0;
      want = 3'h0;
      drv = 3'h0;
      policy = 2'h0;
      altFuse = 1'b0;
      romPrintTx = 1'b1;
      repeat (16) @(posedge core_clk);
      resetn <= 1'b1;
      t_pull();
      t_causes();
      t_regs();
      t_print();
      end_sim();
   end
endmodule
bind strap_latch_boot_select slbs_chk chk_i (.core_clk, .resetn, .porReset,
   .lpWdtReset, .brownoutReset, .anaWdtReset, .glitchReset, .boot_select_pin,
   .bootSelectDriven, .print_gate_pin, .printGateDriven, .printPolicyFuse,
   .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
   .systemInReset, .bootMode, .printEnable);
`default_nettype wire
